// ---- src/fault_gate_pkg.sv ----
package fault_gate_pkg;

    // Register word offsets on the plain register port (byte addresses)
    localparam logic [7:0] OFS_FAULT_REACTION = 8'h00;
    localparam logic [7:0] OFS_GATE_CTRL      = 8'h04;
    localparam logic [7:0] OFS_FAULT_STATUS   = 8'h08;

    // Fault reaction field
    localparam int         REACT_LSB    = 0;
    localparam int         REACT_WIDTH  = 2;
    localparam logic [1:0] REACT_RESET  = 2'h0;
    localparam int         REACT_ERR_BIT = 0;
    localparam int         REACT_IRQ_BIT = 1;

    // Gate register layout
    localparam int MAX_FILTERS    = 4;
    localparam int GATE_REQ_LSB   = 0;
    localparam int GATE_STAT_LSB  = 16;
    localparam int FAULT_FLAG_BIT = 0;

    // Every implemented gate comes out of reset open
    localparam logic [MAX_FILTERS-1:0] GATE_REQ_RESET = 4'hf;

    // Outstanding transaction counter per filter unit
    localparam int OUTST_WIDTH = 8;

    // Bus response encodings
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    // One-hot gate states
    typedef enum logic [2:0] {
        GATE_OPEN  = 3'h1,
        GATE_DRAIN = 3'h2,
        GATE_SHUT  = 3'h4
    } gate_state_t;

    // Fault events reported by the region checker, one-cycle pulses
    typedef struct packed {
        logic wrRespValid;
        logic wrPermFail;
        logic rdRespValid;
        logic rdPermFail;
        logic overlapErr;
    } fault_evt_t;

    // Responses returned upstream
    typedef struct packed {
        logic       wrValid;
        logic [1:0] wrResp;
        logic       rdValid;
        logic [1:0] rdResp;
    } resp_out_t;

    // Register port request
    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } reg_req_t;

endpackage : fault_gate_pkg

// ---- src/fault_reaction_and_gate_ctrl.sv ----
`timescale 1ns/1ps
// Summary of operation
// - Selector 00: interrupt low, OKAY response
// - Selector 01: interrupt low, DECERR response
// - Selector 10: interrupt high, OKAY response
// - Selector 11: interrupt high, DECERR response
// - Overlap errors never alter bus responses
// - Overlap region>=1: interrupt follows selector high bit
// - Gate fields N bits; rest reserved zero
// - Filter count parameter limited one to four
// - Upper sixteen gate bits read-only
// - Filter k status at bit 16+k
// - Status one means gate open
// - Status zero means gate closed
// - Status stays one until outstanding drained
// - Request one opens, zero closes
// - Request bit k controls filter k
// - Clear needs refusal and no outstanding accesses
module fault_reaction_and_gate_ctrl #(
    parameter int NUM_FILTERS = 4
) (
    input  wire logic                     clk_sys,
    input  wire logic                     rst_b,
    input  wire fault_gate_pkg::reg_req_t regReq,
    output logic [31:0]                   regRdata,
    input  wire fault_gate_pkg::fault_evt_t faultEvt,
    output fault_gate_pkg::resp_out_t     respOut,
    output logic                          security_fault_irq,
    input  wire logic [NUM_FILTERS-1:0]   cmdAccepted,
    input  wire logic [NUM_FILTERS-1:0]   txnCompleted,
    output logic [NUM_FILTERS-1:0]        gateAdmit
);
    import fault_gate_pkg::*;

    // Out-of-range counts stop elaboration instead of silently wrapping
    if (NUM_FILTERS < 1 || NUM_FILTERS > MAX_FILTERS) begin : g_bad_count
        $error("filter count must lie between one and four");
    end

    logic [1:0]             reactValue_ff;
    logic [NUM_FILTERS-1:0] openRequest_ff;
    logic [NUM_FILTERS-1:0] openStatus;
    logic                   faultFlag_ff;
    logic [31:0]            rdMux;
    logic [31:0]            regRdata_ff;
    resp_out_t              respOut_ff;
    resp_out_t              nxt_respOut;
    logic                   irqEvent;
    logic                   wrFaultReg;
    logic                   wrGateReg;
    logic                   wrStatusReg;

    logic                   wrFail;
    logic                   rdFail;
    logic                   irqClear;
    logic                   permIrq;
    logic                   overlapIrq;

    logic [31:0]            reactWord;
    logic [31:0]            gateWord;
    logic [31:0]            statusWord;

    assign wrFaultReg  = regReq.wr && (regReq.addr == OFS_FAULT_REACTION);
    assign wrGateReg   = regReq.wr && (regReq.addr == OFS_GATE_CTRL);
    assign wrStatusReg = regReq.wr && (regReq.addr == OFS_FAULT_STATUS);

    // Permission failures only count alongside their response strobe
    assign wrFail   = faultEvt.wrRespValid && faultEvt.wrPermFail;
    assign rdFail   = faultEvt.rdRespValid && faultEvt.rdPermFail;

    // Writing one clears the flag; writing zero leaves it alone
    assign irqClear = wrStatusReg && regReq.wdata[FAULT_FLAG_BIT];

    // Fault reaction selector
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            reactValue_ff <= REACT_RESET;
        end else if (wrFaultReg) begin
            reactValue_ff <= regReq.wdata[REACT_LSB +: REACT_WIDTH];
        end
    end

    // Only the low N request bits are stored; reserved and status bits drop
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            openRequest_ff <= GATE_REQ_RESET[NUM_FILTERS-1:0];
        end else if (wrGateReg) begin
            openRequest_ff <= regReq.wdata[GATE_REQ_LSB +: NUM_FILTERS];
        end
    end

    // Bus responses: only permission failures pick DECERR, overlaps never
    always_comb begin
        nxt_respOut         = '0;
        nxt_respOut.wrValid = faultEvt.wrRespValid;
        nxt_respOut.rdValid = faultEvt.rdRespValid;
        if (wrFail) begin
            nxt_respOut.wrResp = reactValue_ff[REACT_ERR_BIT] ? RESP_DECERR
                                                               : RESP_OKAY;
        end else begin
            nxt_respOut.wrResp = RESP_OKAY;
        end
        if (rdFail) begin
            nxt_respOut.rdResp = reactValue_ff[REACT_ERR_BIT] ? RESP_DECERR
                                                               : RESP_OKAY;
        end else begin
            nxt_respOut.rdResp = RESP_OKAY;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            respOut_ff <= '0;
        end else begin
            respOut_ff <= nxt_respOut;
        end
    end

    assign respOut = respOut_ff;

    // Interrupt raising events: permission failures and overlaps alike
    assign permIrq    = reactValue_ff[REACT_IRQ_BIT] && (wrFail || rdFail);
    assign overlapIrq = reactValue_ff[REACT_IRQ_BIT] && faultEvt.overlapErr;
    assign irqEvent   = permIrq || overlapIrq;

    // Level held until software writes one to clear; a new event wins the clear
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            faultFlag_ff <= 1'b0;
        end else if (irqEvent) begin
            faultFlag_ff <= 1'b1;
        end else if (irqClear) begin
            faultFlag_ff <= 1'b0;
        end
    end

    // Selector 00 and 01 never set the flag, so the line stays low
    assign security_fault_irq = faultFlag_ff;

    // Per filter unit gate keeper
    for (genvar k = 0; k < NUM_FILTERS; k++) begin : g_gate
        gate_state_t            state_ff;
        gate_state_t            nxt_state;
        logic [OUTST_WIDTH-1:0] outst_ff;
        logic                   admitted;
        logic                   drained;
        logic                   admitNow;
        logic                   statusNow;

        // A refused command never reaches the filter, so it is not counted
        assign admitted = cmdAccepted[k] && gateAdmit[k];

        // Empty now, or emptied by the completion on this very edge
        assign drained = (outst_ff == '0) ||
                         (outst_ff == OUTST_WIDTH'(1) && txnCompleted[k]);

        // Counter saturates; masters are trusted not to exceed its range
        always_ff @(posedge clk_sys) begin
            if (!rst_b) begin
                outst_ff <= '0;
            end else if (admitted && !txnCompleted[k] && outst_ff != '1) begin
                outst_ff <= outst_ff + OUTST_WIDTH'(1);
            end else if (!admitted && txnCompleted[k] && outst_ff != '0) begin
                outst_ff <= outst_ff - OUTST_WIDTH'(1);
            end
        end

        always_comb begin
            nxt_state = state_ff;
            case (state_ff)
                GATE_OPEN: begin
                    if (!openRequest_ff[k]) begin
                        nxt_state = GATE_DRAIN;
                    end else begin
                        nxt_state = GATE_OPEN;
                    end
                end
                GATE_DRAIN: begin
                    if (openRequest_ff[k]) begin
                        nxt_state = GATE_OPEN;
                    end else if (drained) begin
                        nxt_state = GATE_SHUT;
                    end else begin
                        nxt_state = GATE_DRAIN;
                    end
                end
                GATE_SHUT: begin
                    if (openRequest_ff[k]) begin
                        nxt_state = GATE_OPEN;
                    end else begin
                        nxt_state = GATE_SHUT;
                    end
                end
                default: begin
                    nxt_state = GATE_SHUT;
                end
            endcase
        end

        always_ff @(posedge clk_sys) begin
            if (!rst_b) begin
                state_ff <= GATE_OPEN;
            end else begin
                state_ff <= nxt_state;
            end
        end

        // Admission stops as soon as closing starts; stalled masters may
        // deadlock the bus, which is the price of a clean drain
        // Status stays open while draining, drops only once fully shut
        always_comb begin
            admitNow  = 1'b0;
            statusNow = 1'b0;
            case (state_ff)
                GATE_OPEN: begin
                    admitNow  = 1'b1;
                    statusNow = 1'b1;
                end
                GATE_DRAIN: begin
                    admitNow  = 1'b0;
                    statusNow = 1'b1;
                end
                GATE_SHUT: begin
                    admitNow  = 1'b0;
                    statusNow = 1'b0;
                end
                default: begin
                    admitNow  = 1'b0;
                    statusNow = 1'b0;
                end
            endcase
        end

        assign gateAdmit[k]  = admitNow;
        assign openStatus[k] = statusNow;
    end

    // Register images; reserved and absent filter bits read zero
    always_comb begin
        reactWord                           = '0;
        reactWord[REACT_LSB +: REACT_WIDTH] = reactValue_ff;
    end

    always_comb begin
        gateWord                               = '0;
        gateWord[GATE_REQ_LSB +: NUM_FILTERS]  = openRequest_ff;
        gateWord[GATE_STAT_LSB +: NUM_FILTERS] = openStatus;
    end

    always_comb begin
        statusWord                 = '0;
        statusWord[FAULT_FLAG_BIT] = faultFlag_ff;
    end

    // Read data, one cycle after the strobe; unmapped reads zero
    always_comb begin
        rdMux = '0;
        case (regReq.addr)
            OFS_FAULT_REACTION: begin
                rdMux = reactWord;
            end
            OFS_GATE_CTRL: begin
                rdMux = gateWord;
            end
            OFS_FAULT_STATUS: begin
                rdMux = statusWord;
            end
            default: begin
                rdMux = '0;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            regRdata_ff <= '0;
        end else if (regReq.rd) begin
            regRdata_ff <= rdMux;
        end else begin
            regRdata_ff <= '0;
        end
    end

    assign regRdata = regRdata_ff;

endmodule : fault_reaction_and_gate_ctrl

// ---- tb/fault_gate_monitor.sv ----
`timescale 1ns/1ps
module fault_gate_monitor #(
    parameter int NUM_FILTERS = 4
) (
    input wire logic                       clk_sys,
    input wire logic                       rst_b,
    input wire fault_gate_pkg::reg_req_t   regReq,
    input wire logic [31:0]                regRdata,
    input wire fault_gate_pkg::fault_evt_t faultEvt,
    input wire fault_gate_pkg::resp_out_t  respOut,
    input wire logic                       security_fault_irq,
    input wire logic [NUM_FILTERS-1:0]     gateAdmit
);
    import fault_gate_pkg::*;
    logic [1:0] react_ff;
    // Shadow of the selector, since it never leaves the block
    always_ff @(posedge clk_sys) begin
        if (!rst_b) react_ff <= REACT_RESET;
        else if (regReq.wr && regReq.addr == OFS_FAULT_REACTION) react_ff <= regReq.wdata[1:0];
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    sequence gateClose;
        regReq.wr && regReq.addr == OFS_GATE_CTRL && !regReq.wdata[0];
    endsequence
    sequence gateOpen;
        regReq.wr && regReq.addr == OFS_GATE_CTRL && regReq.wdata[0];
    endsequence
    chk_wr_valid: assert property (faultEvt.wrRespValid |=> respOut.wrValid)
        else $error("write response missing");
    chk_resp_idle: assert property (!faultEvt.wrRespValid && !faultEvt.rdRespValid
        |=> !respOut.wrValid && !respOut.rdValid) else $error("stray response");
    chk_wr_decerr: assert property (faultEvt.wrRespValid && faultEvt.wrPermFail && react_ff[0]
        |=> respOut.wrResp == RESP_DECERR) else $error("write not DECERR");
    chk_wr_okay: assert property (faultEvt.wrRespValid && !(faultEvt.wrPermFail && react_ff[0])
        |=> respOut.wrResp == RESP_OKAY) else $error("write not OKAY");
    chk_rd_resp: assert property (faultEvt.rdRespValid |=> respOut.rdValid && respOut.rdResp ==
        (($past(faultEvt.rdPermFail) && $past(react_ff[0])) ? RESP_DECERR : RESP_OKAY))
        else $error("read response wrong");
    chk_irq_quiet: assert property (!react_ff[1] && !security_fault_irq && !regReq.wr
        |=> !security_fault_irq) else $error("interrupt raised");
    chk_irq_raise: assert property (react_ff[1] && ((faultEvt.wrRespValid && faultEvt.wrPermFail)
        || (faultEvt.rdRespValid && faultEvt.rdPermFail) || faultEvt.overlapErr)
        |=> security_fault_irq) else $error("interrupt not raised");
    chk_gate_shut: assert property (gateClose |-> ##2 !gateAdmit[0])
        else $error("gate still admits");
    chk_gate_open: assert property (gateOpen |-> ##2 gateAdmit[0])
        else $error("gate not reopened");
    chk_rdata_idle: assert property (!regReq.rd |=> regRdata == 32'h0)
        else $error("read data outside read");
    chk_reserved_zero: assert property (regReq.rd |=> regRdata[15:NUM_FILTERS] == '0 &&
        regRdata[31:16+NUM_FILTERS] == '0) else $error("reserved bits set");
endmodule : fault_gate_monitor
bind fault_reaction_and_gate_ctrl fault_gate_monitor #(.NUM_FILTERS(NUM_FILTERS)) monitor_i (
    .clk_sys(clk_sys), .rst_b(rst_b), .regReq(regReq), .regRdata(regRdata),
    .faultEvt(faultEvt), .respOut(respOut), .security_fault_irq(security_fault_irq),
    .gateAdmit(gateAdmit));

// ---- tb/far_side_model.sv ----
`timescale 1ns/1ps
module far_side_model #(
    parameter int NUM_FILTERS = 4
) (
    input  wire logic                   clk_sys,
    input  wire logic                   rst_b,
    input  wire logic [NUM_FILTERS-1:0] gateAdmit,
    input  wire logic [NUM_FILTERS-1:0] issue,
    input  wire logic [NUM_FILTERS-1:0] retire,
    output logic [NUM_FILTERS-1:0]      cmdAccepted,
    output logic [NUM_FILTERS-1:0]      txnCompleted
);
    logic [NUM_FILTERS-1:0] busy_ff;
    // A shut gate stalls the command; software must plan for that wait
    assign cmdAccepted = issue & gateAdmit;
    // One access in flight per filter, so a completion needs one pending
    assign txnCompleted = retire & busy_ff;
    always_ff @(posedge clk_sys) begin
        if (!rst_b) busy_ff <= '0;
        else busy_ff <= (busy_ff | cmdAccepted) & ~txnCompleted;
    end
endmodule : far_side_model

// ---- tb/tb.sv ----
`timescale 1ns/1ps
`define CHK(nm, e, g) begin totalChecks++; if ((g) !== (e)) begin mismatches++; \
    $display("mismatch %s expected %h seen %h", nm, e, g); end end
module tb;
    import fault_gate_pkg::*;
    localparam int NF = 4;
    logic          clk_sys = 1'b0;
    logic          rst_b = 1'b0;
    reg_req_t      regReq = '0;
    fault_evt_t    faultEvt = '0;
    logic [NF-1:0] issue = '0;
    logic [NF-1:0] retire = '0;
    logic [31:0]   regRdata;
    resp_out_t     respOut;
    logic          security_fault_irq;
    logic [NF-1:0] cmdAccepted, txnCompleted, gateAdmit;
    int            mismatches = 0;
    int            totalChecks = 0;
    always #25 clk_sys = ~clk_sys;
    fault_reaction_and_gate_ctrl #(.NUM_FILTERS(NF)) fault_reaction_and_gate_ctrl_i (
        .clk_sys(clk_sys), .rst_b(rst_b), .regReq(regReq), .regRdata(regRdata),
        .faultEvt(faultEvt), .respOut(respOut), .security_fault_irq(security_fault_irq),
        .cmdAccepted(cmdAccepted), .txnCompleted(txnCompleted), .gateAdmit(gateAdmit));
    far_side_model #(.NUM_FILTERS(NF)) far_side_model_i (.clk_sys(clk_sys), .rst_b(rst_b),
        .gateAdmit(gateAdmit), .issue(issue), .retire(retire), .cmdAccepted(cmdAccepted),
        .txnCompleted(txnCompleted));
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys) regReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_sys) regReq.wr <= 1'b0;
    endtask : wr_reg
    task automatic rd_reg(input logic [7:0] a, input logic [31:0] e, input string nm);
        @(posedge clk_sys) regReq <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge clk_sys) regReq.rd <= 1'b0;
        #1 `CHK(nm, e, regRdata)
    endtask : rd_reg
    task automatic fault_evt(input logic pf, input logic ov, input logic [1:0] r);
        #1 `CHK("irqClear", 1'b0, security_fault_irq)
        @(posedge clk_sys) faultEvt <= '{1'b1, pf, 1'b1, pf, ov};
        @(posedge clk_sys) faultEvt <= '0;
        #1 `CHK("valid", 2'h3, {respOut.wrValid, respOut.rdValid})
        `CHK("wrResp", (pf && r[0]) ? RESP_DECERR : RESP_OKAY, respOut.wrResp)
        `CHK("rdResp", (pf && r[0]) ? RESP_DECERR : RESP_OKAY, respOut.rdResp)
        `CHK("irq", r[1], security_fault_irq)
    endtask : fault_evt
    task automatic test_reaction();
        for (int r = 0; r < 4; r++) begin
            wr_reg(OFS_FAULT_REACTION, 32'(r));
            fault_evt(1'b1, 1'b0, 2'(r));
            wr_reg(OFS_FAULT_STATUS, 32'h1);
            fault_evt(1'b0, 1'b1, 2'(r));
            wr_reg(OFS_FAULT_STATUS, 32'h1);
        end
        rd_reg(OFS_FAULT_REACTION, 32'h3, "reaction");
        rd_reg(8'h0c, 32'h0, "unmapped");
        $display("test reaction done");
    endtask : test_reaction
    task automatic test_gate();
        rd_reg(OFS_GATE_CTRL, 32'h000f_000f, "gateReset");
        @(posedge clk_sys) issue <= 4'h1;
        @(posedge clk_sys) issue <= 4'h0;
        // Upper half written with ones must leave status untouched
        wr_reg(OFS_GATE_CTRL, 32'hffff_000e);
        @(posedge clk_sys);
        #1 `CHK("admitShut", 4'he, gateAdmit)
        @(posedge clk_sys) issue <= 4'h1;
        repeat (2) @(posedge clk_sys);
        #1 `CHK("stalled", 4'h0, cmdAccepted)
        rd_reg(OFS_GATE_CTRL, 32'h000f_000e, "draining");
        @(posedge clk_sys) retire <= 4'h1;
        @(posedge clk_sys) retire <= 4'h0;
        rd_reg(OFS_GATE_CTRL, 32'h000e_000e, "shut");
        wr_reg(OFS_GATE_CTRL, 32'h0000_000f);
        @(posedge clk_sys);
        #1 `CHK("admitOpen", 4'hf, gateAdmit)
        @(posedge clk_sys) issue <= 4'h0;
        @(posedge clk_sys) retire <= 4'h1;
        @(posedge clk_sys) retire <= 4'h0;
        rd_reg(OFS_GATE_CTRL, 32'h000f_000f, "reopened");
        $display("test gate done");
    endtask : test_gate
    task automatic finish_test();
        $display("checks %0d mismatches %0d", totalChecks, mismatches);
        if (mismatches == 0 && totalChecks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : finish_test
    initial begin
        repeat (10) @(posedge clk_sys);
        rst_b <= 1'b1;
        test_reaction();
        test_gate();
        finish_test();
    end
    // Cuts a hang short at 4000 cycles, about fifty times the normal run length
    initial begin
        #200us;
        mismatches++;
        finish_test();
    end
endmodule : tb
